// ---- core/lscl_pkg.sv ----
// constants and types shared by the light sensor command logic
package lscl_pkg;
   // one-byte opcodes
   localparam logic [7:0] OP_POWER_DOWN = 8'h00;
   localparam logic [7:0] OP_POWER_ON   = 8'h01;
   localparam logic [7:0] OP_CLEAR      = 8'h07;
   localparam logic [7:0] OP_CONT_HIGH  = 8'h10;
   localparam logic [7:0] OP_CONT_HALF  = 8'h11;
   localparam logic [7:0] OP_CONT_LOW   = 8'h13;
   localparam logic [7:0] OP_ONCE_HIGH  = 8'h20;
   localparam logic [7:0] OP_ONCE_HALF  = 8'h21;
   localparam logic [7:0] OP_ONCE_LOW   = 8'h23;
   // split loads of the integration length
   localparam logic [4:0] OP_LEN_UPPER_PFX = 5'h08;
   localparam logic [2:0] OP_LEN_LOWER_PFX = 3'h3;
   // seven-bit bus addresses chosen by the address-select pin
   localparam logic [6:0] BUS_ADDR_SEL_HIGH = 7'h5c;
   localparam logic [6:0] BUS_ADDR_SEL_LOW  = 7'h23;
   // values after reset
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [7:0]  LENGTH_RESET = 8'h45;
   // measurement timing at the default integration length
   localparam int CLK_HZ       = 125_000_000;
   localparam int HIGH_TIME_MS = 120;
   localparam int LOW_TIME_MS  = 16;
   localparam int HIGH_UNIT_CYCLES = (HIGH_TIME_MS * (CLK_HZ / 1000)) / int'(LENGTH_RESET);
   localparam int LOW_UNIT_CYCLES  = (LOW_TIME_MS * (CLK_HZ / 1000)) / int'(LENGTH_RESET);
   localparam int UNIT_W = 18;
   // bus bit counter
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   typedef enum logic [1:0] {PWR_DOWN, PWR_IDLE, PWR_MEAS} lscl_power_type;
   typedef enum logic [1:0] {RES_HIGH, RES_HALF, RES_LOW} lscl_res_type;
   typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_WR_BYTE, BUS_ACK_WR,
                             BUS_RD_BYTE, BUS_RD_ACK} lscl_bus_type;
endpackage : lscl_pkg

// ---- core/lscl_bus_slave.sv ----
// two-wire bus slave: one opcode byte per write, result bytes on read
`timescale 1ns/1ps
`default_nettype none
module lscl_bus_slave (
   input  wire logic        ref_clk,    // block clock
   input  wire logic        sys_rst,    // async reset, high
   input  wire logic        scl_in,     // bus clock pin
   input  wire logic        sda_in,     // bus data pin level
   output logic             sda_out,    // data pin drive value
   output logic             sda_oe,     // data pin drive enable
   input  wire logic        addr_sel,   // address-select pin
   input  wire logic [15:0] result,     // result for read-out
   output logic             op_valid,   // one-cycle opcode strobe
   output logic [7:0]       op_byte     // opcode with the strobe
);
   import lscl_pkg::*;

   typedef struct packed {
      logic [1:0]   scl_sync;
      logic         scl_prev;
      logic [1:0]   sda_sync;
      logic         sda_prev;
      logic [1:0]   addr_sync;
      lscl_bus_type phase;
      logic [3:0]   cnt;
      logic [7:0]   shift;
      logic         rw;
      logic         got_op;
      logic [7:0]   op;
      logic         op_pulse;
      logic         drive;
      logic [15:0]  tx;
      logic         acked;
   } lscl_slave_state_type;

   lscl_slave_state_type st_ff, nxt_st;
   logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
   logic [6:0] my_addr;

   // pins are read only after the second sync stage
   assign scl_s      = st_ff.scl_sync[1];
   assign sda_s      = st_ff.sda_sync[1];
   assign scl_rise   = scl_s & ~st_ff.scl_prev;
   assign scl_fall   = ~scl_s & st_ff.scl_prev;
   assign start_cond = scl_s & st_ff.scl_prev & st_ff.sda_prev & ~sda_s;
   assign stop_cond  = scl_s & st_ff.scl_prev & ~st_ff.sda_prev & sda_s;
   assign my_addr    = st_ff.addr_sync[1] ? BUS_ADDR_SEL_HIGH : BUS_ADDR_SEL_LOW;

   // bus phase sequencing
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.scl_sync  = {st_ff.scl_sync[0], scl_in};
      nxt_st.sda_sync  = {st_ff.sda_sync[0], sda_in};
      nxt_st.addr_sync = {st_ff.addr_sync[0], addr_sel};
      nxt_st.scl_prev  = scl_s;
      nxt_st.sda_prev  = sda_s;
      nxt_st.op_pulse  = 1'b0;
      if (start_cond) begin
         nxt_st.phase  = BUS_ADDR;
         nxt_st.cnt    = 4'h0;
         nxt_st.got_op = 1'b0;
         nxt_st.drive  = 1'b0;
      end else if (stop_cond) begin
         // opcode acts at the stop, so one byte per transaction
         nxt_st.op_pulse = st_ff.got_op;
         nxt_st.got_op   = 1'b0;
         nxt_st.phase    = BUS_IDLE;
         nxt_st.drive    = 1'b0;
      end else if (scl_rise) begin
         if (st_ff.phase == BUS_ADDR || st_ff.phase == BUS_WR_BYTE) begin
            nxt_st.shift = {st_ff.shift[6:0], sda_s};
            nxt_st.cnt   = st_ff.cnt + 4'h1;
         end else if (st_ff.phase == BUS_RD_ACK) begin
            nxt_st.acked = ~sda_s;
         end
      end else if (scl_fall) begin
         case (st_ff.phase)
            BUS_ADDR: begin
               if (st_ff.cnt == BITS_PER_BYTE) begin
                  if (st_ff.shift[7:1] == my_addr) begin
                     nxt_st.rw    = st_ff.shift[0];
                     nxt_st.drive = 1'b1;
                     nxt_st.phase = BUS_ACK_ADDR;
                  end else begin
                     nxt_st.phase = BUS_IDLE;
                  end
               end
            end
            BUS_ACK_ADDR: begin
               nxt_st.cnt = 4'h0;
               if (st_ff.rw) begin
                  // snapshot keeps both bytes from one measurement
                  nxt_st.tx    = result;
                  nxt_st.drive = ~result[15];
                  nxt_st.phase = BUS_RD_BYTE;
               end else begin
                  nxt_st.drive = 1'b0;
                  nxt_st.phase = BUS_WR_BYTE;
               end
            end
            BUS_WR_BYTE: begin
               if (st_ff.cnt == BITS_PER_BYTE) begin
                  // a second byte in one transaction is not acknowledged
                  if (!st_ff.got_op) begin
                     nxt_st.got_op = 1'b1;
                     nxt_st.op     = st_ff.shift;
                     nxt_st.drive  = 1'b1;
                     nxt_st.phase  = BUS_ACK_WR;
                  end else begin
                     nxt_st.phase = BUS_IDLE;
                  end
               end
            end
            BUS_ACK_WR: begin
               nxt_st.drive = 1'b0;
               nxt_st.cnt   = 4'h0;
               nxt_st.phase = BUS_WR_BYTE;
            end
            BUS_RD_BYTE: begin
               if (st_ff.cnt == LAST_TX_BIT) begin
                  nxt_st.drive = 1'b0;
                  nxt_st.phase = BUS_RD_ACK;
               end else begin
                  nxt_st.tx    = {st_ff.tx[14:0], 1'b0};
                  nxt_st.drive = ~st_ff.tx[14];
                  nxt_st.cnt   = st_ff.cnt + 4'h1;
               end
            end
            BUS_RD_ACK: begin
               if (st_ff.acked) begin
                  nxt_st.tx    = {st_ff.tx[14:0], 1'b0};
                  nxt_st.drive = ~st_ff.tx[14];
                  nxt_st.cnt   = 4'h0;
                  nxt_st.phase = BUS_RD_BYTE;
               end else begin
                  nxt_st.phase = BUS_IDLE;
               end
            end
            default: nxt_st.phase = BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff       <= '0;
         st_ff.phase <= BUS_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // open drain: only ever pulls low
   assign sda_out  = 1'b0;
   assign sda_oe   = st_ff.drive;
   assign op_valid = st_ff.op_pulse;
   assign op_byte  = st_ff.op;
endmodule // lscl_bus_slave
`default_nettype wire

// ---- core/lscl_top.sv ----
// light sensor command logic: opcode decode, measurement timing, result
//
// Notes on behaviour
// - opcode 00 powers down, 01 powers on idle
// - measurement opcodes accepted straight from power-down
// - opcode 07 zeroes result, keeps everything else
// - result clear ignored while powered down
// - 10: continuous high resolution, 120 ms
// - 11: continuous half-step mode, 120 ms
// - 13: continuous low resolution, 16 ms
// - 20/21/23 measure once, then power down
// - 011xxxxx loads integration length bits 4..0
// - 16-bit result register, resets to zero
// - 8-bit integration length, resets to 0x45
// - internal clock only, no external clock
// - reset clears all registers except length (loads 0x45), powered down
// - continuous modes overwrite result every period
// - one opcode per write, then stop
// - address 1011100 if select high, else 0100011
// - measurement time proportional to integration length
`timescale 1ns/1ps
`default_nettype none
module lscl_top #(
   parameter int HIGH_UNIT = lscl_pkg::HIGH_UNIT_CYCLES, // cycles per length step, high res
   parameter int LOW_UNIT  = lscl_pkg::LOW_UNIT_CYCLES   // cycles per length step, low res
) (
   input  wire logic        ref_clk,                 // block clock, 125 MHz
   input  wire logic        sys_rst,                 // async reset, high
   input  wire logic        scl_in,                  // bus clock pin
   input  wire logic        sda_in,                  // bus data pin level
   output logic             sda_out,                 // data pin drive value
   output logic             sda_oe,                  // data pin drive enable
   input  wire logic        addr_sel,                // address-select pin
   input  wire logic [15:0] conv_count,              // converter output count
   output logic             photo_diode_on,          // front end powered
   output logic             integrating,             // measurement running
   output logic             half_step_mode,          // half-step resolution chosen
   output logic             low_res_mode,            // low resolution chosen
   output logic             period_done,             // one-cycle end of measurement
   output logic [7:0]       integration_length_bits, // integration length
   output logic [15:0]      illuminance_result       // held result
);
   import lscl_pkg::*;

   typedef struct packed {
      lscl_power_type    power;
      lscl_res_type      res;
      logic              cont;
      logic [UNIT_W-1:0] unit_cnt;
      logic [7:0]        len_cnt;
      logic [7:0]        length;
      logic [15:0]       result;
      logic              done;
   } lscl_top_state_type;

   lscl_top_state_type st_ff, nxt_st;
   logic              op_valid;
   logic [7:0]        op_byte;
   logic [UNIT_W-1:0] unit_last;
   logic              len_last;
   logic              len_hi_op;  // opcode loads length bits 7..5
   logic              len_lo_op;  // opcode loads length bits 4..0

   // bus slave feeds opcodes in and reads the result out
   lscl_bus_slave u_bus (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe   (sda_oe),
      .addr_sel (addr_sel),
      .result   (st_ff.result),
      .op_valid (op_valid),
      .op_byte  (op_byte)
   );

   // period = length steps of a per-resolution unit, so time scales with length
   assign unit_last = (st_ff.res == RES_LOW) ? UNIT_W'(LOW_UNIT - 1)
                                             : UNIT_W'(HIGH_UNIT - 1);
   // >= instead of == so a length lowered mid-period still ends it
   assign len_last  = ({1'b0, st_ff.len_cnt} + 9'h001) >= {1'b0, st_ff.length};

   // length loads are told apart by prefix; the low bits carry the value
   assign len_hi_op = (op_byte[7:3] == OP_LEN_UPPER_PFX);
   assign len_lo_op = (op_byte[7:5] == OP_LEN_LOWER_PFX);

   // measurement timing, then opcode decode; a command beats a period end
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      // unit steps nest inside length steps
      if (st_ff.power == PWR_MEAS) begin
         if (st_ff.unit_cnt == unit_last) begin
            nxt_st.unit_cnt = '0;
            if (len_last) begin
               nxt_st.len_cnt = 8'h00;
               nxt_st.result  = conv_count;
               nxt_st.done    = 1'b1;
               if (!st_ff.cont) begin
                  nxt_st.power = PWR_DOWN;
               end
            end else begin
               nxt_st.len_cnt = st_ff.len_cnt + 8'h01;
            end
         end else begin
            nxt_st.unit_cnt = st_ff.unit_cnt + UNIT_W'(1);
         end
      end
      // decode comes last, so a command overrides a period end
      if (op_valid) begin
         case (op_byte)
            OP_POWER_DOWN: begin
               nxt_st.power = PWR_DOWN;
            end
            OP_POWER_ON: begin
               nxt_st.power = PWR_IDLE;
            end
            OP_CLEAR: begin
               // only the result; length and power state stay
               if (st_ff.power != PWR_DOWN) begin
                  nxt_st.result = RESULT_RESET;
               end
            end
            // repeated measurements; taken in any power state, a running period is dropped
            OP_CONT_HIGH: begin
               // 1 lx step, rerun every period
               nxt_st.power    = PWR_MEAS;
               nxt_st.cont     = 1'b1;
               nxt_st.res      = RES_HIGH;
               nxt_st.unit_cnt = '0;
               nxt_st.len_cnt  = 8'h00;
            end
            OP_CONT_HALF: begin
               // half step, same period as the 1 lx mode
               nxt_st.power    = PWR_MEAS;
               nxt_st.cont     = 1'b1;
               nxt_st.res      = RES_HALF;
               nxt_st.unit_cnt = '0;
               nxt_st.len_cnt  = 8'h00;
            end
            OP_CONT_LOW: begin
               // 4 lx step on the short unit
               nxt_st.power    = PWR_MEAS;
               nxt_st.cont     = 1'b1;
               nxt_st.res      = RES_LOW;
               nxt_st.unit_cnt = '0;
               nxt_st.len_cnt  = 8'h00;
            end

            // single measurements; power drops again at the period end
            OP_ONCE_HIGH: begin
               // one period at 1 lx step
               nxt_st.power    = PWR_MEAS;
               nxt_st.cont     = 1'b0;
               nxt_st.res      = RES_HIGH;
               nxt_st.unit_cnt = '0;
               nxt_st.len_cnt  = 8'h00;
            end
            OP_ONCE_HALF: begin
               // one period at half step
               nxt_st.power    = PWR_MEAS;
               nxt_st.cont     = 1'b0;
               nxt_st.res      = RES_HALF;
               nxt_st.unit_cnt = '0;
               nxt_st.len_cnt  = 8'h00;
            end
            OP_ONCE_LOW: begin
               // one short period at 4 lx step
               nxt_st.power    = PWR_MEAS;
               nxt_st.cont     = 1'b0;
               nxt_st.res      = RES_LOW;
               nxt_st.unit_cnt = '0;
               nxt_st.len_cnt  = 8'h00;
            end
            default: begin
               // undefined opcodes fall through here and change nothing
               if (len_hi_op) begin
                  nxt_st.length[7:5] = op_byte[2:0];
               end else if (len_lo_op) begin
                  nxt_st.length[4:0] = op_byte[4:0];
               end
            end
         endcase
      end
   end

   // ref_clk stands in for the on-chip oscillator
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff        <= '0;
         st_ff.power  <= PWR_DOWN;
         st_ff.res    <= RES_HIGH;
         // fields with a non-zero reset value are set by name
         st_ff.length <= LENGTH_RESET;
         st_ff.result <= RESULT_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from state flops
   assign photo_diode_on          = (st_ff.power != PWR_DOWN);
   assign integrating             = (st_ff.power == PWR_MEAS);
   assign half_step_mode          = (st_ff.res == RES_HALF);
   assign low_res_mode            = (st_ff.res == RES_LOW);

   // strobe and held registers for the read-out side
   assign period_done             = st_ff.done;
   assign integration_length_bits = st_ff.length;
   assign illuminance_result      = st_ff.result;
endmodule // lscl_top
`default_nettype wire

// ---- sim/lscl_properties.sv ----
// port checker for the light sensor command logic
`timescale 1ns/1ps
`default_nettype none
module lscl_properties #(
   parameter int HIGH_UNIT = 6, // clocks per step, high
   parameter int LOW_UNIT  = 3  // clocks per step, low
) (
   input wire logic        ref_clk,                 // clock
   input wire logic        sys_rst,                 // reset
   input wire logic        scl_in,                  // bus clock
   input wire logic        sda_oe,                  // data drive
   input wire logic [15:0] conv_count,              // count in
   input wire logic        photo_diode_on,          // powered
   input wire logic        integrating,             // running
   input wire logic        half_step_mode,          // half step
   input wire logic        low_res_mode,            // low res
   input wire logic        period_done,             // period end
   input wire logic [7:0]  integration_length_bits, // length
   input wire logic [15:0] illuminance_result       // result
);
   typedef struct packed {
      logic [31:0] cnt;  // clocks into period
      logic [1:0]  mode; // last resolution
   } lscl_chk_type;
   lscl_chk_type chk_ff;
   lscl_chk_type nxt_chk;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // restart at period end or mode switch; same-mode restarts go unseen
   always_comb begin
      nxt_chk = chk_ff;
      nxt_chk.mode = {half_step_mode, low_res_mode};
      if (period_done || nxt_chk.mode != chk_ff.mode) begin
         nxt_chk.cnt = 32'h2;
      end else if (!integrating) begin
         nxt_chk.cnt = 32'h1;
      end else begin
         nxt_chk.cnt = chk_ff.cnt + 32'h1;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         chk_ff <= '0;
      end else begin
         chk_ff <= nxt_chk;
      end
   end
   a_result_on_done:
      assert property (period_done |-> illuminance_result == $past(conv_count))
      else $error("result is not the count at period end");
   a_result_clear_only:
      assert property ($changed(illuminance_result) && !period_done
         |-> illuminance_result == 16'h0 && $past(photo_diode_on))
      else $error("result changed without period end or clear");
   a_done_one_cycle:
      assert property (period_done |=> !period_done) else $error("period end too long");
   a_running_powered:
      assert property (integrating |-> photo_diode_on) else $error("running while down");
   a_reset_values:
      assert property ($fell(sys_rst) |-> !photo_diode_on && !integrating
         && integration_length_bits == 8'h45 && illuminance_result == 16'h0)
      else $error("wrong state after reset");
   a_period_length:
      assert property (period_done |-> chk_ff.cnt == 32'(integration_length_bits)
         * (chk_ff.mode[0] ? LOW_UNIT : HIGH_UNIT) + 1)
      else $error("period length wrong");
   a_oneshot_down:
      assert property (period_done && !integrating |-> !photo_diode_on)
      else $error("still powered after single measurement");
   a_drive_clock_low:
      assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data drive moved while bus clock high");
   a_one_mode:
      assert property (!(half_step_mode && low_res_mode)) else $error("two modes at once");
   c_continuous: cover property (period_done && integrating);
   c_oneshot: cover property (period_done && !integrating);
   c_ack: cover property ($rose(sda_oe));
endmodule // lscl_properties
bind lscl_top lscl_properties #(.HIGH_UNIT(HIGH_UNIT), .LOW_UNIT(LOW_UNIT)) chk_u (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_oe(sda_oe),
   .conv_count(conv_count), .photo_diode_on(photo_diode_on), .integrating(integrating),
   .half_step_mode(half_step_mode), .low_res_mode(low_res_mode), .period_done(period_done),
   .integration_length_bits(integration_length_bits), .illuminance_result(illuminance_result));
`default_nettype wire

// ---- sim/lscl_bus_master.sv ----
// two-wire bus master model opposite the sensor's bus pins
`timescale 1ns/1ps
`default_nettype none
module lscl_bus_master (
   input  wire logic ref_clk, // bench clock
   input  wire logic sda_oe,  // sensor pulls data low
   output var  logic scl,     // bus clock, still between frames
   output wire logic sda      // resolved data line
);
   logic m_low = 1'b0; // master pulls data low
   int   stretch = 0;  // extra low clocks, slow master
   // pull-up: high unless a party pulls it down
   assign sda = ~(m_low | sda_oe);
   initial scl = 1'b1;
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // data moves only while clock is low; sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      wt(1);
      m_low = ~b;
      wt(4 + stretch);
      scl = 1'b1;
      wt(2);
      r = sda;
      wt(1);
      scl = 1'b0;
   endtask
   task automatic tx_byte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], r);
      end
      bit_io(1'b1, ack);
   endtask
   task automatic start();
      m_low = 1'b0;
      wt(4);
      m_low = 1'b1;
      wt(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      wt(1);
      m_low = 1'b1;
      wt(4);
      scl = 1'b1;
      wt(4);
      m_low = 1'b0;
      wt(4);
   endtask
   task automatic wr_op(input logic [6:0] a, input logic [7:0] op, output logic [1:0] ack);
      start();
      tx_byte({a, 1'b0}, ack[1]);
      tx_byte(op, ack[0]);
      stop();
   endtask
   // high byte acked, low byte nacked to end the read
   task automatic rd_res(input logic [6:0] a, output logic [15:0] v, output logic ack);
      logic r;
      start();
      tx_byte({a, 1'b1}, ack);
      for (int i = 15; i >= 0; i--) begin
         bit_io(1'b1, v[i]);
         if (i == 8) bit_io(1'b0, r);
      end
      bit_io(1'b1, r);
      stop();
   endtask
endmodule // lscl_bus_master
`default_nettype wire

// ---- sim/light_sensor_command_logic_bench.sv ----
// self-checking bench for the light sensor command logic
`timescale 1ns/1ps
`default_nettype none
module light_sensor_command_logic_bench import lscl_pkg::*;;
   localparam int HU = 6;
   localparam int LU = 3;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        addr_sel = 1'b0;
   logic [15:0] conv_count = 16'h0;
   logic        scl, sda, sda_oe, pd_on, integ, half_m, low_m, done;
   logic [7:0]  len;
   logic [15:0] res;
   logic        sda_drv;
   logic [6:0]  dev = 7'h23;
   int          n_mismatch = 0;
   int          check_count = 0;
   always #4 ref_clk = ~ref_clk;
   lscl_bus_master bus_u (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   lscl_top #(.HIGH_UNIT(HU), .LOW_UNIT(LU)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
      .sda_oe(sda_oe), .addr_sel(addr_sel), .conv_count(conv_count),
      .photo_diode_on(pd_on), .integrating(integ), .half_step_mode(half_m),
      .low_res_mode(low_m), .period_done(done), .integration_length_bits(len),
      .illuminance_result(res));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded, so a stuck period counter cannot hang the run
   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (done !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         n_mismatch++;
         test_done();
      end
   endtask
   task automatic send(input logic [7:0] op);
      logic [1:0] a;
      bus_u.wr_op(dev, op, a);
      check(a, 2'b00);
      wt(8);
   endtask
   task automatic s_reset();
      check(res, 16'h0);
      check(len, 8'h45);
      check({pd_on, integ}, 2'b00);
      check(sda_drv, 1'b0);
   endtask
   task automatic s_address();
      logic [1:0] a;
      addr_sel = 1'b1;
      wt(4);
      bus_u.wr_op(7'h23, OP_POWER_ON, a);
      check(a, 2'b11);
      dev = 7'h5c;
      send(OP_POWER_ON);
      check({pd_on, integ}, 2'b10);
      send(OP_POWER_DOWN);
      check(pd_on, 1'b0);
      addr_sel = 1'b0;
      dev = 7'h23;
      wt(4);
   endtask
   // single measurement from power-down, period timed from the command
   task automatic run_once(input logic [7:0] op, input logic [1:0] m, input int np);
      int n;
      conv_count = conv_count + 16'h1;
      send(op);
      check({pd_on, integ, half_m, low_m}, {2'b11, m});
      wait_done(n);
      check(res, conv_count);
      check({pd_on, integ}, 2'b00);
      check(n >= np - 10 && n <= np - 4, 1'b1);
   endtask
   task automatic s_once();
      logic [7:0] ops [3] = '{OP_ONCE_HIGH, OP_ONCE_HALF, OP_ONCE_LOW};
      logic [1:0] ms [3] = '{2'b00, 2'b10, 2'b01};
      int         ps [3] = '{69 * HU, 69 * HU, 69 * LU};
      for (int i = 0; i < 3; i++) begin
         run_once(ops[i], ms[i], ps[i]);
      end
      send(OP_CLEAR);
      check(res, conv_count);
      send(OP_POWER_ON);
      send(OP_CLEAR);
      check(res, 16'h0);
      check(len, 8'h45);
   endtask
   // the second and third mode switches land mid-period, so each also abandons a measurement; the first starts from idle
   task automatic s_cont();
      logic [7:0]  ops [3] = '{OP_CONT_HIGH, OP_CONT_HALF, OP_CONT_LOW};
      logic [1:0]  ms [3] = '{2'b00, 2'b10, 2'b01};
      int          ps [3] = '{69 * HU, 69 * HU, 69 * LU};
      int          n;
      logic [15:0] v;
      logic        a;
      for (int i = 0; i < 3; i++) begin
         conv_count = 16'ha000 + 16'(i);
         send(ops[i]);
         if (i > 0) check(res, 16'hb000 + 16'(i - 1));
         check({integ, half_m, low_m}, {1'b1, ms[i]});
         wait_done(n);
         check(res, conv_count);
         conv_count = 16'hb000 + 16'(i);
         wait_done(n);
         check(16'(n), 16'(ps[i]));
         check(res, conv_count);
      end
      bus_u.stretch = 3;
      bus_u.rd_res(dev, v, a);
      bus_u.stretch = 0;
      check(v, conv_count);
      check(a, 1'b0);
   endtask
   task automatic s_length();
      send(OP_POWER_DOWN);
      send(8'h44);
      send(8'h6a);
      check(len, 8'h8a);
      run_once(OP_ONCE_LOW, 2'b01, 8'h8a * LU);
   endtask
   initial begin
      wt(12);
      sys_rst = 1'b0;
      wt(4);
      s_reset();
      s_address();
      s_once();
      s_cont();
      s_length();
      sys_rst = 1'b1;
      wt(3);
      s_reset();
      sys_rst = 1'b0;
      wt(4);
      test_done();
   end
endmodule // light_sensor_command_logic_bench
`default_nettype wire
